//--- design/tsi_top.sv
// Three-source interrupt unit of an 8-bit controller: flags, enables,
// global enable, pin edge detect, wake latch and one-level context save.
// Assumes a synchronous APB master, a core that acknowledges vectoring and
// event inputs that are synchronous one-cycle pulses or levels.
//
// Notes on behaviour
// - Per-source enable bit gates vectoring.
// - Taking interrupt steps stack, loads vector 8.
// - Service state ends only on return.
// - Enables at bits 0, 4, 5, reset zero.
// - Flags set by events, cleared by software.
// - Flags at bits 0, 4, 5, reset zero.
// - Global enable bit 7 required for service.
// - Entry clears global enable, return sets it.
// - Save/restore accumulator and flags, skip reset causes.
// - Pin edge sets flag regardless of enable.
// - Enabled pin edge vectors to address 8.
// - Power-down pin edge latched, serviced first; unit only flags it on service_first_out, no priority.
// - Edge field 4:3, reset falling edge.
// - Timer overflow sets flag regardless of enable.
// - Timer vectors only when enabled.
// - Counter overflow sets flag regardless of enable.
// - Counter flag and enable together vector.
`timescale 1ns/1ps
`include "tsi_cfg.svh"

module tsi_top (
    input  wire logic        clk_in,         // System clock, 10 MHz.
    input  wire logic        nrst_in,        // Asynchronous reset, low.
    input  wire logic        psel_in,        // APB select.
    input  wire logic        penable_in,     // APB access phase.
    input  wire logic        pwrite_in,      // APB direction, high write.
    input  wire logic [11:0] paddr_in,       // APB byte address.
    input  wire logic [31:0] pwdata_in,      // APB write data.
    output logic      [31:0] prdata_out,     // APB read data.
    output logic             pready_out,     // APB ready, no wait.
    output logic             pslverr_out,    // APB error, unmapped.
    input  wire logic        pin_in,         // External interrupt pin.
    input  wire logic        timer_ovf_in,   // Timer overflow pulse.
    input  wire logic        tc_ovf_in,      // Timer/counter overflow.
    input  wire logic        powerdown_in,   // Core in power-down mode.
    output logic             irq_req_out,    // Vectoring request.
    input  wire logic        take_in,        // Core takes the request.
    input  wire logic        ret_in,         // Return from service.
    output logic             pc_load_out,    // Load vector, one pulse.
    output logic      [7:0]  vector_out,     // Vector address.
    output logic             in_service_out, // Service state.
    output logic             service_first_out, // Wake edge pending.
    input  wire logic        push_in,        // Save context.
    input  wire logic        pop_in,         // Restore context.
    input  wire logic [7:0]  acc_in,         // Accumulator to save.
    input  wire logic [7:0]  flags_in,       // Program flags now.
    output logic      [7:0]  acc_out,        // Restored accumulator.
    output logic      [7:0]  flags_out,      // Restored program flags.
    output logic             pop_valid_out   // Restored values valid.
);

    // ------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------
    tsi_pkg::tsi_regs_t st;
    tsi_pkg::tsi_regs_t next_st;

    logic       hit_edge;
    logic       hit_flags;
    logic       hit_enable;
    logic       hit_stack;
    logic       hit_any;

    logic       setup_ph;
    logic       wr_acc;

    logic       pin_rise;
    logic       pin_fall;
    logic       pin_event;

    logic       take_ok;
    logic       ret_ok;

    logic [7:0] flag_byte;
    logic [7:0] enable_byte;
    logic [7:0] edge_byte;
    logic [7:0] stack_byte;

    // Each register owns one aligned word at four times its index.
    // Unmapped words read zero and take no write.
    assign hit_edge   = paddr_in == {2'h0, `TSI_IDX_EDGE, 2'h0};
    assign hit_flags  = paddr_in == {2'h0, `TSI_IDX_FLAGS, 2'h0};
    assign hit_enable = paddr_in == {2'h0, `TSI_IDX_ENABLE, 2'h0};
    assign hit_stack  = paddr_in == {2'h0, `TSI_IDX_STACK, 2'h0};
    assign hit_any    = hit_edge | hit_flags | hit_enable | hit_stack;
    assign setup_ph   = psel_in & ~penable_in;
    assign wr_acc     = psel_in & penable_in & pwrite_in & hit_any;

    // ------------------------------------------------------------------
    // Pin edge qualification
    // ------------------------------------------------------------------
    // The reserved code triggers nothing, so a bad setting stays quiet.
    // The prior sample resets low, as an idle pin does.
    assign pin_rise  = pin_in & ~st.pin_prev;
    assign pin_fall  = ~pin_in & st.pin_prev;
    always_comb begin
        case (st.edge_sel)
            `TSI_EDGE_RISE: pin_event = pin_rise;
            `TSI_EDGE_FALL: pin_event = pin_fall;
            `TSI_EDGE_BOTH: pin_event = pin_rise | pin_fall;
            default:        pin_event = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Vectoring request
    // ------------------------------------------------------------------
    // No hardware priority: software sorts sources out in the handler.
    // A level, so a slow core loses nothing.
    assign irq_req_out = st.global_irq_enable & (st.state == tsi_pkg::TSI_IDLE)
        & ((st.pin_flag & st.pin_en)
         | (st.tmr_flag & st.tmr_en)
         | (st.tc_flag & st.tc_en));
    assign take_ok = take_in & irq_req_out;
    assign ret_ok  = ret_in & (st.state == tsi_pkg::TSI_SERVICE);

    // Read images of the four registers; reserved bits read zero.
    always_comb begin
        flag_byte                  = `TSI_BYTE_ZERO;
        flag_byte[`TSI_BIT_PIN]    = st.pin_flag;
        flag_byte[`TSI_BIT_TMR]    = st.tmr_flag;
        flag_byte[`TSI_BIT_TC]     = st.tc_flag;
        enable_byte                = `TSI_BYTE_ZERO;
        enable_byte[`TSI_BIT_PIN]  = st.pin_en;
        enable_byte[`TSI_BIT_TMR]  = st.tmr_en;
        enable_byte[`TSI_BIT_TC]   = st.tc_en;
        edge_byte                  = `TSI_BYTE_ZERO;
        edge_byte[`TSI_EDGE_HI:`TSI_EDGE_LO] = st.edge_sel;
        stack_byte                 = `TSI_BYTE_ZERO;
        stack_byte[`TSI_BIT_GIE]   = st.global_irq_enable;
        stack_byte[`TSI_STACK_HI:`TSI_STACK_LO] = st.stack;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st           = st;
        next_st.pin_prev  = pin_in;
        next_st.pop_valid = 1'b0;
        next_st.pc_load   = 1'b0;

        // Read data is caught in the setup phase so it comes from a flop.
        // A write at an access edge shows on the next read.
        if (setup_ph) begin
            next_st.rdata = `TSI_WORD_ZERO;
            if (hit_edge)   next_st.rdata[7:0] = edge_byte;
            if (hit_flags)  next_st.rdata[7:0] = flag_byte;
            if (hit_enable) next_st.rdata[7:0] = enable_byte;
            if (hit_stack)  next_st.rdata[7:0] = stack_byte;
        end

        // Software writes land at the access edge.
        if (wr_acc && hit_edge) begin
            next_st.edge_sel = pwdata_in[`TSI_EDGE_HI:`TSI_EDGE_LO];
        end

        if (wr_acc && hit_flags) begin
            next_st.pin_flag = pwdata_in[`TSI_BIT_PIN];
            next_st.tmr_flag = pwdata_in[`TSI_BIT_TMR];
            next_st.tc_flag  = pwdata_in[`TSI_BIT_TC];
        end

        if (wr_acc && hit_enable) begin
            next_st.pin_en   = pwdata_in[`TSI_BIT_PIN];
            next_st.tmr_en   = pwdata_in[`TSI_BIT_TMR];
            next_st.tc_en    = pwdata_in[`TSI_BIT_TC];
        end

        if (wr_acc && hit_stack) begin
            next_st.global_irq_enable   = pwdata_in[`TSI_BIT_GIE];
            next_st.stack = pwdata_in[`TSI_STACK_HI:`TSI_STACK_LO];
        end

        // Events come after the write so a set beats a clear.
        if (pin_event) next_st.pin_flag = 1'b1;
        if (timer_ovf_in) next_st.tmr_flag = 1'b1;
        if (tc_ovf_in) next_st.tc_flag = 1'b1;

        // Entry and exit of service win over a same-cycle write.
        // The stack field counts down on entry.
        case (st.state)
            tsi_pkg::TSI_IDLE: begin
                if (take_ok) begin
                    next_st.state      = tsi_pkg::TSI_SERVICE;
                    next_st.global_irq_enable        = 1'b0;
                    next_st.stack      = st.stack - `TSI_STACK_STEP;
                    next_st.pc_load    = 1'b1;
                    next_st.wake_latch = 1'b0;
                end
            end
            tsi_pkg::TSI_SERVICE: begin
                if (ret_ok) begin
                    next_st.state = tsi_pkg::TSI_IDLE;
                    next_st.global_irq_enable   = 1'b1;
                    next_st.stack = st.stack + `TSI_STACK_STEP;
                end
            end
            default: next_st.state = tsi_pkg::TSI_IDLE;
        endcase

        // A wake edge is held until the core enters service. It is set
        // after the take, so an edge in that very cycle is kept for the
        // next entry instead of being lost.
        if (powerdown_in && pin_event) next_st.wake_latch = 1'b1;

        // One-level buffer; the reset-cause bits are never saved.
        // Push wins if the core asks for both at once.
        if (push_in) begin
            next_st.save_acc   = acc_in;
            next_st.save_flags = flags_in & ~`TSI_RCAUSE_MASK;
        end else if (pop_in) begin
            next_st.acc       = st.save_acc;
            next_st.flags     = st.save_flags | (flags_in & `TSI_RCAUSE_MASK);
            next_st.pop_valid = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset loads constants only.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st            <= '0;
            st.state      <= tsi_pkg::TSI_IDLE;
            st.edge_sel   <= `TSI_EDGE_RST;
            st.stack      <= `TSI_STACK_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Zero-wait slave: the setup phase has already fetched the data.
    // Every source shares the one fixed vector.
    assign pready_out        = 1'b1;
    assign pslverr_out       = psel_in & penable_in & ~hit_any;
    assign prdata_out        = st.rdata;
    assign pc_load_out       = st.pc_load;
    assign vector_out        = `TSI_VECTOR;
    assign in_service_out    = st.state == tsi_pkg::TSI_SERVICE;
    assign service_first_out = st.wake_latch;
    assign acc_out           = st.acc;
    assign flags_out         = st.flags;
    assign pop_valid_out     = st.pop_valid;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // All checks stand down while reset is low.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    a_entry_clears_gie: assert property (
        take_ok |=> !st.global_irq_enable && in_service_out)
        else $error("Entry did not clear global enable.");

    a_vector_load: assert property (
        take_ok |=> pc_load_out && vector_out == `TSI_VECTOR
            && st.stack == $past(st.stack) - `TSI_STACK_STEP)
        else $error("Vector or stack step wrong on entry.");

    a_return_sets_gie: assert property (
        ret_ok |=> st.global_irq_enable && !in_service_out)
        else $error("Return did not restore global enable.");

    a_service_holds: assert property (
        in_service_out && !ret_in |=> in_service_out)
        else $error("Service state left without return.");

    a_request_terms: assert property (
        irq_req_out == (st.global_irq_enable && !in_service_out
            && |(flag_byte & enable_byte)))
        else $error("Request does not match enables and flags.");

    a_pin_flag_set: assert property (
        pin_event |=> st.pin_flag)
        else $error("Pin edge did not set its flag.");

    a_timer_flags_set: assert property (
        timer_ovf_in || tc_ovf_in |=>
            (st.tmr_flag || !$past(timer_ovf_in))
            && (st.tc_flag || !$past(tc_ovf_in)))
        else $error("Overflow did not set its flag.");

    a_flag_sticky: assert property (
        st.pin_flag && !(wr_acc && hit_flags) |=> st.pin_flag)
        else $error("Pin flag dropped without software clear.");

    a_wake_first: assert property (
        powerdown_in && pin_event |=> service_first_out)
        else $error("Wake edge was not latched.");

    // The save holds the value seen at the push edge.
    a_push_save: assert property (
        push_in |=> st.save_acc == $past(acc_in))
        else $error("Saved accumulator differs from input.");

    a_pop_restore: assert property (
        pop_in && !push_in |=> pop_valid_out
            && acc_out == $past(st.save_acc))
        else $error("Restored accumulator differs from saved one.");

    // Reset-cause bits follow the live flags, never the buffer,
    // so a restore cannot fake a reset cause.
    a_pop_rcause: assert property (
        pop_in && !push_in |=> (flags_out & `TSI_RCAUSE_MASK)
            == ($past(flags_in) & `TSI_RCAUSE_MASK))
        else $error("Restore touched the reset-cause bits.");

    // Entry leaves idle at once, so no second load can follow.
    a_pc_pulse: assert property (
        pc_load_out |=> !pc_load_out)
        else $error("Vector load lasted more than one cycle.");

    // Service is entered only by an accepted take.
    a_entry_only_take: assert property (
        !in_service_out && !take_ok |=> !in_service_out)
        else $error("Service entered without a take.");

    // Nothing may be requested while a routine runs.
    a_no_req_service: assert property (
        in_service_out |-> !irq_req_out)
        else $error("Request raised during service.");

endmodule // tsi_top

//--- design/tsi_cfg.svh
// Constants of the three-source interrupt unit: register indices, field
// positions, reset values and encodings.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TSI_CFG_SVH
`define TSI_CFG_SVH

// Register indices; the APB byte address is four times the index.
`define TSI_IDX_EDGE     8'hBF
`define TSI_IDX_FLAGS    8'hC8
`define TSI_IDX_ENABLE   8'hC9
`define TSI_IDX_STACK    8'hDF
`define TSI_ADDR_W       12

// Field positions; bits 0, 4 and 5 are shared by the flag and enable registers.
`define TSI_BIT_PIN      0
`define TSI_BIT_TMR      4
`define TSI_BIT_TC       5
`define TSI_BIT_GIE      7
`define TSI_EDGE_LO      3
`define TSI_EDGE_HI      4
`define TSI_STACK_HI     1
`define TSI_STACK_LO     0

// Reset values.
`define TSI_EDGE_RST     2'h2
`define TSI_STACK_RST    2'h3
`define TSI_BYTE_ZERO    8'h00
`define TSI_WORD_ZERO    32'h00000000

// Pin trigger encodings.
`define TSI_EDGE_NONE    2'h0
`define TSI_EDGE_RISE    2'h1
`define TSI_EDGE_FALL    2'h2
`define TSI_EDGE_BOTH    2'h3

// Shared vector address, the reset-cause bits kept out of the save and the stack step.
`define TSI_VECTOR       8'h08
`define TSI_RCAUSE_MASK  8'hC0
`define TSI_STACK_STEP   2'h1

`endif

//--- design/tsi_pkg.sv
// Types of the three-source interrupt unit.
// Assumes tsi_cfg.svh is on the include path.
`include "tsi_cfg.svh"

package tsi_pkg;

    // Service state of the unit.
    typedef enum logic {
        TSI_IDLE,
        TSI_SERVICE
    } tsi_state_t;

    // Whole state of the unit, registered in one process.
    typedef struct packed {
        tsi_state_t  state;
        logic [1:0]  edge_sel;
        logic        pin_flag;
        logic        tmr_flag;
        logic        tc_flag;
        logic        pin_en;
        logic        tmr_en;
        logic        tc_en;
        logic        global_irq_enable;
        logic [1:0]  stack;
        logic        pin_prev;
        logic        wake_latch;
        logic [7:0]  save_acc;
        logic [7:0]  save_flags;
        logic [7:0]  acc;
        logic [7:0]  flags;
        logic        pop_valid;
        logic        pc_load;
        logic [31:0] rdata;
    } tsi_regs_t;

endpackage

//--- testbench/tsi_core_model.sv
// Core-side partner of the interrupt unit: takes vectoring, saves and
// restores context and returns. Assumes one clock shared with the unit.
`timescale 1ns/1ps

module tsi_core_model #(
    parameter int HOLD = 40                // Service length in cycles.
) (
    input  wire logic       clk_in,        // System clock.
    input  wire logic       nrst_in,       // Reset, active low.
    input  wire logic       irq_req_in,    // Vectoring request.
    input  wire logic       in_service_in, // Service state.
    input  wire logic [3:0] delay_in,      // Cycles before taking.
    output logic            take_out,      // Take pulse.
    output logic            ret_out,       // Return pulse.
    output logic            push_out,      // Save pulse.
    output logic            pop_out        // Restore pulse.
);
    // ------------------------------------------------------------------
    // Core sequence
    // ------------------------------------------------------------------
    int wait_n;
    int hold_n;

    // A slow core lets the request stand; the routine saves early and
    // restores late, so the bench has time to clear flags in between.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {take_out, ret_out, push_out, pop_out} <= 4'h0;
            wait_n <= 0;
            hold_n <= 0;
        end else begin
            take_out <= 1'b0;
            ret_out  <= 1'b0;
            if (!in_service_in) begin
                hold_n   <= 0;
                push_out <= 1'b0;
                pop_out  <= 1'b0;
                if (irq_req_in && !take_out) begin
                    wait_n <= wait_n + 1;
                    if (wait_n >= int'(delay_in)) begin
                        take_out <= 1'b1;
                        wait_n   <= 0;
                    end
                end
            end else begin
                hold_n   <= hold_n + 1;
                push_out <= (hold_n == 1);
                pop_out  <= (hold_n == HOLD - 4);
                if (hold_n == HOLD) begin
                    ret_out <= 1'b1;
                    hold_n  <= 0;
                end
            end
        end
    end
endmodule // tsi_core_model

//--- testbench/tsi_top_test.sv
// Self-checking bench of the interrupt unit with a cycle model beside it.
// Assumes tsi_cfg.svh on the include path and the core partner model.
`timescale 1ns/1ps
`include "tsi_cfg.svh"

module tsi_top_test;
    localparam logic [11:0] A_ED = {2'b00, `TSI_IDX_EDGE, 2'b00};
    localparam logic [11:0] A_FL = {2'b00, `TSI_IDX_FLAGS, 2'b00};
    localparam logic [11:0] A_EN = {2'b00, `TSI_IDX_ENABLE, 2'b00};
    localparam logic [11:0] A_SK = {2'b00, `TSI_IDX_STACK, 2'b00};
    logic [11:0] addrs [5] = '{A_ED, A_FL, A_EN, A_SK, 12'h100};
    logic        clk_in = 1'b0, nrst_in = 1'b0, psel_in = 1'b0;
    logic        penable_in = 1'b0, pwrite_in = 1'b0, pin_in = 1'b0;
    logic        timer_ovf_in = 1'b0, tc_ovf_in = 1'b0, ev_acc = 1'b0;
    logic        powerdown_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, seed = 32'h00017537;
    logic [7:0]  acc_in = 8'h00, flags_in = 8'h00, vector_out;
    logic [7:0]  acc_out, flags_out, m_fl, m_en, s_acc, s_fl, m_acc, m_flo;
    logic [3:0]  delay_in = 4'h0;
    logic [1:0]  m_edge, m_stk;
    logic        pready_out, pslverr_out, irq_req_out, take_in, ret_in;
    logic        pc_load_out, in_service_out, service_first_out, push_in;
    logic        pop_in, pop_valid_out, m_gie, m_svc, m_wake, m_pcl;
    logic        m_prev, m_popv;
    int          err_total = 0, comparisons = 0;

    tsi_top DUT (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .pin_in(pin_in),
        .timer_ovf_in(timer_ovf_in), .tc_ovf_in(tc_ovf_in),
        .powerdown_in(powerdown_in), .irq_req_out(irq_req_out),
        .take_in(take_in), .ret_in(ret_in), .pc_load_out(pc_load_out),
        .vector_out(vector_out), .in_service_out(in_service_out),
        .service_first_out(service_first_out), .push_in(push_in),
        .pop_in(pop_in), .acc_in(acc_in), .flags_in(flags_in),
        .acc_out(acc_out), .flags_out(flags_out),
        .pop_valid_out(pop_valid_out));

    tsi_core_model u_core (.clk_in(clk_in), .nrst_in(nrst_in),
        .irq_req_in(irq_req_out), .in_service_in(in_service_out),
        .delay_in(delay_in), .take_out(take_in), .ret_out(ret_in),
        .push_out(push_in), .pop_out(pop_in));

    // ------------------------------------------------------------------
    // Clock, random context data and helpers
    // ------------------------------------------------------------------
    initial forever #50 clk_in = ~clk_in;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Context inputs change every cycle so a stale save shows at once.
    always @(posedge clk_in) begin
        seed     <= lfsr(seed);
        acc_in   <= seed[7:0];
        flags_in <= seed[15:8];
    end

    function automatic logic m_req();
        return m_gie && !m_svc && |(m_fl & m_en);
    endfunction

    function automatic logic [31:0] m_rd(input logic [11:0] a);
        case (a)
            A_ED:    return {27'h0, m_edge, 3'h0};
            A_FL:    return {24'h0, m_fl};
            A_EN:    return {24'h0, m_en};
            A_SK:    return {24'h0, m_gie, 5'h00, m_stk};
            default: return 32'h0;
        endcase
    endfunction

    task automatic chk(input string n, input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Reference model, stepped on the same edges as the unit
    // ------------------------------------------------------------------
    always @(posedge clk_in or negedge nrst_in) begin : ref_model
        logic tk, rt, ed;
        if (!nrst_in) begin
            {m_fl, m_en, m_gie, m_svc, m_wake, m_pcl} = 20'h0;
            {m_prev, m_popv} = 2'h0;
            m_edge = `TSI_EDGE_RST;
            m_stk  = `TSI_STACK_RST;
        end else begin
            tk = take_in && m_req();
            rt = ret_in && m_svc;
            case (m_edge)
                `TSI_EDGE_RISE: ed = pin_in && !m_prev;
                `TSI_EDGE_FALL: ed = !pin_in && m_prev;
                `TSI_EDGE_BOTH: ed = pin_in != m_prev;
                default:        ed = 1'b0;
            endcase
            if (psel_in && penable_in && pwrite_in) case (paddr_in)
                A_ED:    m_edge = pwdata_in[4:3];
                A_FL:    m_fl = pwdata_in[7:0] & 8'h31;
                A_EN:    m_en = pwdata_in[7:0] & 8'h31;
                A_SK:    {m_gie, m_stk} = {pwdata_in[7], pwdata_in[1:0]};
                default: ;
            endcase
            m_fl = m_fl | {2'h0, tc_ovf_in, timer_ovf_in, 3'h0, ed};
            if (tk) {m_svc, m_gie, m_stk, m_wake} = {2'b10, m_stk - 2'h1, 1'b0};
            m_wake = m_wake | (ed && powerdown_in);
            if (rt) {m_svc, m_gie, m_stk} = {2'b01, m_stk + 2'h1};
            m_pcl  = tk;
            m_prev = pin_in;
            m_popv = pop_in && !push_in;
            if (m_popv) {m_acc, m_flo} = {s_acc, s_fl | (flags_in & 8'hC0)};
            if (push_in) {s_acc, s_fl} = {acc_in, flags_in & 8'h3F};
        end
    end

    // Outputs are compared mid-cycle, once every edge has settled.
    always @(negedge clk_in) begin
        if (nrst_in) begin
            chk("irq_req", 32'(irq_req_out), 32'(m_req()));
            chk("in_service", 32'(in_service_out), 32'(m_svc));
            chk("pc_load", 32'(pc_load_out), 32'(m_pcl));
            chk("vector", 32'(vector_out), 32'(`TSI_VECTOR));
            chk("wake", 32'(service_first_out), 32'(m_wake));
            chk("pop_valid", 32'(pop_valid_out), 32'(m_popv));
            if (m_popv) chk("ctx", {acc_out, flags_out}, {m_acc, m_flo});
        end
    end

    // ------------------------------------------------------------------
    // Bus and event tasks
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int i;
        @(posedge clk_in);
        {psel_in, penable_in, pwrite_in} <= {2'b10, w};
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in   <= 1'b1;
        timer_ovf_in <= ev_acc;
        for (i = 0; i < 16; i++) begin
            @(posedge clk_in);
            if (pready_out === 1'b1) break;
        end
        if (i == 16) begin err_total++; summarize(); end
        r = prdata_out;
        e = pslverr_out;
        {psel_in, penable_in, timer_ovf_in} <= 3'h0;
    endtask

    task automatic rd(input logic [11:0] a);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk("prdata", r, m_rd(a));
        chk("pslverr", 32'(e), 32'(a == 12'h100));
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk("pslverr", 32'(e), 32'(a == 12'h100));
    endtask

    task automatic fire(input int s);
        @(posedge clk_in);
        case (s)
            0:       pin_in <= !pin_in;
            1:       timer_ovf_in <= 1'b1;
            default: tc_ovf_in <= 1'b1;
        endcase
        @(posedge clk_in);
        {timer_ovf_in, tc_ovf_in} <= 2'h0;
        @(posedge clk_in);
    endtask

    task automatic wait_svc(input logic want);
        int i;
        for (i = 0; i < 200 && in_service_out !== want; i++) @(posedge clk_in);
        if (i == 200) begin err_total++; summarize(); end
    endtask

    // Software picks the source by testing flag and enable, then clears.
    task automatic serve();
        wait_svc(1'b1);
        rd(A_FL);
        rd(A_EN);
        wr(A_FL, 32'h0);
        wait_svc(1'b0);
        rd(A_SK);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin : main
        int i;
        int s;
        repeat (8) @(posedge clk_in);
        nrst_in <= 1'b1;
        for (i = 0; i < 5; i++) rd(addrs[i]);
        wr(12'h100, 32'hFF);
        for (i = 0; i < 15; i++) begin
            wr(addrs[i % 5], {24'h0, seed[7:0] & 8'h7F});
            rd(addrs[i % 5]);
        end
        wr(A_EN, 32'h0);
        for (s = 0; s < 4; s++) begin
            wr(A_ED, 32'(s) << 3);
            fire(0);
            fire(0);
            rd(A_FL);
            wr(A_FL, 32'h0);
        end
        fire(1);
        fire(2);
        rd(A_FL);
        ev_acc = 1'b1;
        wr(A_FL, 32'h0);
        ev_acc = 1'b0;
        rd(A_FL);
        for (s = 0; s < 3; s++) begin
            wr(A_FL, 32'h0);
            wr(A_EN, s == 0 ? 32'h01 : (s == 1 ? 32'h10 : 32'h20));
            wr(A_ED, 32'h18);
            wr(A_SK, 32'h83);
            delay_in <= 4'(s * 3);
            fire((s + 1) % 3);
            fire(s);
            serve();
        end
        wr(A_SK, 32'h0);
        wr(A_EN, 32'h01);
        wr(A_ED, 32'h10);
        @(posedge clk_in);
        {pin_in, powerdown_in} <= 2'b11;
        fire(0);
        powerdown_in <= 1'b0;
        wr(A_SK, 32'h83);
        serve();
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        for (i = 0; i < 4; i++) rd(addrs[i]);
        summarize();
    end
endmodule // tsi_top_test
